/* hw/diag_pkg.sv */
// Constants, register map and field layout of the driver diagnostic block.
// Assumes a classic Wishbone master with 32-bit data and a 50 MHz ref_clk.
package diag_pkg;
  localparam int TEMP_W = 8;
  localparam logic [TEMP_W-1:0] TEMP_PREWARN_C = 8'h78;
  localparam logic [TEMP_W-1:0] TEMP_SHUTDOWN_C = 8'h96;
  localparam int LOAD_W = 10;
  localparam int THR_W = 7;
  localparam int SUM_W = 12;
  localparam int THR_SHIFT = 3;
  localparam logic [2:0] SHORT_DETECTS = 3'h4;
  localparam logic [1:0] FILTER_LAST = 2'h3;
  localparam int FILTER_SHIFT = 2;
  localparam int SYNC_W = 4;
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CONTROL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_THRESHOLD = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_IRQ_STATUS = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h10;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_FILTER = 1;
  localparam int ST_LOAD_LSB = 0;
  localparam int ST_OVERHEAT = 24;
  localparam int ST_PREWARN = 25;
  localparam int ST_SHORT_A = 26;
  localparam int ST_SHORT_B = 27;
  localparam int ST_OPEN_A = 28;
  localparam int ST_OPEN_B = 29;
  localparam int ST_STANDSTILL = 31;
  localparam int IRQ_W = 7;
  localparam int EV_OVERHEAT = 0;
  localparam int EV_PREWARN = 1;
  localparam int EV_SHORT_A = 2;
  localparam int EV_SHORT_B = 3;
  localparam int EV_OPEN_A = 4;
  localparam int EV_OPEN_B = 5;
  localparam int EV_MEASURE = 6;
  localparam logic [THR_W-1:0] THRESHOLD_RESET = 7'h00;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage

/* hw/pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes all bits are independent levels; output follows once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      level <= '0;
    else
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
  end
endmodule
`default_nettype wire

/* hw/driver_diag.sv */
// Diagnostic flags, protection latches and load measurement of a two-coil driver.
// Assumes a classic Wishbone master, digital die temperature and load samples on ref_clk.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module driver_diag (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic [7:0] die_temp,
  input wire logic short_a_pin,
  input wire logic short_b_pin,
  input wire logic current_low_a_pin,
  input wire logic current_low_b_pin,
  input wire logic fullstep,
  input wire logic standstill,
  input wire logic [9:0] raw_load,
  output logic bridge_a_on,
  output logic bridge_b_on
);
  logic [diag_pkg::SYNC_W-1:0] pins_sync;
  logic [1:0] short_lvl;
  logic [1:0] short_prev;
  logic [1:0] current_low;
  logic [2:0] short_count [2];
  logic [1:0] ground_short;
  logic [1:0] open_load;
  logic overheat_shutdown_flag;
  logic prewarn;
  logic driver_enable;
  logic filter_enable;
  logic [diag_pkg::THR_W-1:0] stall_threshold;
  logic [diag_pkg::LOAD_W-1:0] load_measure_value;
  logic [diag_pkg::SUM_W-1:0] filter_sum;
  logic [1:0] filter_phase;
  logic [diag_pkg::IRQ_W-1:0] irq_status;
  logic [diag_pkg::IRQ_W-1:0] irq_mask;
  logic [diag_pkg::IRQ_W-1:0] events;
  logic measure_done;
  logic [31:0] driver_status_word;
  logic [31:0] next_rdata;
  logic [diag_pkg::SUM_W-1:0] adjusted;
  logic [diag_pkg::LOAD_W-1:0] clamped;
  logic [diag_pkg::SUM_W-1:0] filter_total;
  logic bus_req;
  logic wr_take;
  logic rd_take;
  diag_pkg::bus_state_t bus_state;

  pin_sync #(
    .WIDTH(diag_pkg::SYNC_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin({current_low_b_pin, current_low_a_pin, short_b_pin, short_a_pin}),
    .level(pins_sync)
  );

  assign short_lvl = pins_sync[1:0];
  assign current_low = pins_sync[3:2];

  // Bus slave: one wait state, ack for one cycle, then a gap cycle.
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_take = (bus_state == diag_pkg::BUS_ACK) && bus_req && wb_we_i;
  assign rd_take = (bus_state == diag_pkg::BUS_IDLE) && bus_req && !wb_we_i;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      bus_state <= diag_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      case (bus_state)
        diag_pkg::BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_state <= diag_pkg::BUS_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        diag_pkg::BUS_ACK:
        begin
          bus_state <= diag_pkg::BUS_DONE;
          wb_ack_o <= 1'b0;
        end
        diag_pkg::BUS_DONE:
        begin
          bus_state <= diag_pkg::BUS_IDLE;
        end
        default:
        begin
          bus_state <= diag_pkg::BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      driver_enable <= 1'b0;
      filter_enable <= 1'b0;
      stall_threshold <= diag_pkg::THRESHOLD_RESET;
      irq_mask <= '0;
    end
    else if (wr_take && wb_sel_i[0])
    begin
      case (wb_adr_i)
        diag_pkg::ADR_CONTROL:
        begin
          driver_enable <= wb_dat_i[diag_pkg::CTRL_ENABLE];
          filter_enable <= wb_dat_i[diag_pkg::CTRL_FILTER];
        end
        diag_pkg::ADR_THRESHOLD: stall_threshold <= wb_dat_i[diag_pkg::THR_W-1:0];
        diag_pkg::ADR_IRQ_MASK: irq_mask <= wb_dat_i[diag_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    driver_status_word = '0;
    driver_status_word[diag_pkg::ST_LOAD_LSB +: diag_pkg::LOAD_W] = load_measure_value;
    driver_status_word[diag_pkg::ST_OVERHEAT] = overheat_shutdown_flag;
    driver_status_word[diag_pkg::ST_PREWARN] = prewarn;
    driver_status_word[diag_pkg::ST_SHORT_A] = ground_short[0];
    driver_status_word[diag_pkg::ST_SHORT_B] = ground_short[1];
    driver_status_word[diag_pkg::ST_OPEN_A] = open_load[0];
    driver_status_word[diag_pkg::ST_OPEN_B] = open_load[1];
    driver_status_word[diag_pkg::ST_STANDSTILL] = standstill;
  end

  always_comb
  begin
    next_rdata = '0;
    case (wb_adr_i)
      diag_pkg::ADR_CONTROL:
      begin
        next_rdata[diag_pkg::CTRL_ENABLE] = driver_enable;
        next_rdata[diag_pkg::CTRL_FILTER] = filter_enable;
      end
      diag_pkg::ADR_THRESHOLD: next_rdata[diag_pkg::THR_W-1:0] = stall_threshold;
      diag_pkg::ADR_STATUS: next_rdata = driver_status_word;
      diag_pkg::ADR_IRQ_STATUS: next_rdata[diag_pkg::IRQ_W-1:0] = irq_status;
      diag_pkg::ADR_IRQ_MASK: next_rdata[diag_pkg::IRQ_W-1:0] = irq_mask;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      wb_dat_o <= '0;
    else if (rd_take)
      wb_dat_o <= next_rdata;
  end

  // Temperature: live prewarning and a shutdown latch released only below prewarning.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      prewarn <= 1'b0;
      overheat_shutdown_flag <= 1'b0;
    end
    else
    begin
      prewarn <= die_temp >= diag_pkg::TEMP_PREWARN_C;
      if (die_temp >= diag_pkg::TEMP_SHUTDOWN_C)
        overheat_shutdown_flag <= 1'b1;
      else if (die_temp < diag_pkg::TEMP_PREWARN_C)
        overheat_shutdown_flag <= 1'b0;
    end
  end

  // Short to ground: count detections per coil, confirm after the retries.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      short_prev <= '0;
      ground_short <= '0;
      short_count[0] <= '0;
      short_count[1] <= '0;
    end
    else
    begin
      short_prev <= short_lvl;
      for (int c = 0; c < 2; c++)
      begin
        if (!driver_enable)
        begin
          ground_short[c] <= 1'b0;
          short_count[c] <= '0;
        end
        else if (short_lvl[c] && !short_prev[c] && !ground_short[c])
        begin
          if (short_count[c] == diag_pkg::SHORT_DETECTS - 3'h1)
          begin
            ground_short[c] <= 1'b1;
            short_count[c] <= '0;
          end
          else
            short_count[c] <= short_count[c] + 3'h1;
        end
        else if (fullstep && !short_lvl[c])
          short_count[c] <= '0;
      end
    end
  end

  // Bridges: open-load flags deliberately take no part here.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      bridge_a_on <= 1'b0;
      bridge_b_on <= 1'b0;
    end
    else
    begin
      bridge_a_on <= driver_enable && !overheat_shutdown_flag && !ground_short[0];
      bridge_b_on <= driver_enable && !overheat_shutdown_flag && !ground_short[1];
    end
  end

  // Open load: evaluated at each fullstep while moving, held during standstill.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      open_load <= '0;
    else if (fullstep && !standstill)
      open_load <= current_low;
  end

  // Load measurement: threshold shifts the raw reading, clamped to the result range.
  assign adjusted = {2'h0, raw_load}
    + ({{(diag_pkg::SUM_W-diag_pkg::THR_W){stall_threshold[diag_pkg::THR_W-1]}}, stall_threshold}
    << diag_pkg::THR_SHIFT);

  always_comb
  begin
    if (adjusted[diag_pkg::SUM_W-1])
      clamped = '0;
    else if (|adjusted[diag_pkg::SUM_W-2:diag_pkg::LOAD_W])
      clamped = '1;
    else
      clamped = adjusted[diag_pkg::LOAD_W-1:0];
  end

  assign filter_total = filter_sum + {2'b00, clamped};

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      load_measure_value <= '0;
      filter_sum <= '0;
      filter_phase <= '0;
      measure_done <= 1'b0;
    end
    else
    begin
      measure_done <= 1'b0;
      if (fullstep)
      begin
        if (!filter_enable)
        begin
          load_measure_value <= clamped;
          filter_sum <= '0;
          filter_phase <= '0;
          measure_done <= 1'b1;
        end
        else if (filter_phase == diag_pkg::FILTER_LAST)
        begin
          load_measure_value <= filter_total[diag_pkg::FILTER_SHIFT +: diag_pkg::LOAD_W];
          filter_sum <= '0;
          filter_phase <= '0;
          measure_done <= 1'b1;
        end
        else
        begin
          filter_sum <= filter_total;
          filter_phase <= filter_phase + 2'h1;
        end
      end
    end
  end

  // Interrupts: sticky events, cleared by reading the interrupt status; a new event wins.
  always_comb
  begin
    events = '0;
    events[diag_pkg::EV_OVERHEAT] = (die_temp >= diag_pkg::TEMP_SHUTDOWN_C) && !overheat_shutdown_flag;
    events[diag_pkg::EV_PREWARN] = (die_temp >= diag_pkg::TEMP_PREWARN_C) && !prewarn;
    events[diag_pkg::EV_SHORT_A] = driver_enable && short_lvl[0] && !short_prev[0] && !ground_short[0]
      && (short_count[0] == diag_pkg::SHORT_DETECTS - 3'h1);
    events[diag_pkg::EV_SHORT_B] = driver_enable && short_lvl[1] && !short_prev[1] && !ground_short[1]
      && (short_count[1] == diag_pkg::SHORT_DETECTS - 3'h1);
    events[diag_pkg::EV_OPEN_A] = fullstep && !standstill && current_low[0] && !open_load[0];
    events[diag_pkg::EV_OPEN_B] = fullstep && !standstill && current_low[1] && !open_load[1];
    events[diag_pkg::EV_MEASURE] = measure_done;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq_status <= '0;
    else if (rd_take && (wb_adr_i == diag_pkg::ADR_IRQ_STATUS))
      irq_status <= events;
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |((irq_status | events) & irq_mask);
  end
endmodule
`default_nettype wire

/* dv/driver_diag_properties.sv */
// Port assertions for the driver diagnostic block.
// Assumes one ref_clk domain with synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module driver_diag_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] die_temp,
  input wire logic bridge_a_on,
  input wire logic bridge_b_on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ack_bound_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("request not answered");
  unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h10) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved without ack");
  hot_off_a: assert property (die_temp >= 8'h96 |-> ##2 !bridge_a_on && !bridge_b_on)
    else $error("bridges on above shutdown level");
  stay_off_a: assert property (die_temp >= 8'h96 ##1 (die_temp >= 8'h78) [*3] |-> !bridge_a_on && !bridge_b_on)
    else $error("bridges on before cooling");
  cool_on_a: assert property (bridge_a_on || bridge_b_on |-> $past(die_temp, 2) < 8'h96)
    else $error("bridge on after hot sample");
endmodule
bind driver_diag driver_diag_properties chk_u (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .die_temp(die_temp), .bridge_a_on(bridge_a_on), .bridge_b_on(bridge_b_on));
`default_nettype wire

/* dv/wb_host.sv */
// Host controller model: classic Wishbone master for the diagnostic block.
// Assumes one caller at a time; the bench watchdog ends a missing ack.
`timescale 1ns/100ps
`default_nettype none
module wb_host (
  input wire logic ref_clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  initial {cyc, stb, we, adr, sel, wdat} = 47'h0;
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
    do
      @(posedge ref_clk);
    while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we, wdat} <= {3'h0, ~d};
  endtask
endmodule
`default_nettype wire

/* dv/tb_driver_diag.sv */
// Self-checking bench for the driver diagnostic block.
// Assumes wb_host as bus master and the package register map.
`timescale 1ns/100ps
`default_nettype none
module tb_driver_diag;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, bridge_a_on, bridge_b_on;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] die_temp = 8'h19;
  logic [1:0] short_pin = 2'h0;
  logic [1:0] low_pin = 2'h0;
  logic fullstep = 1'b0;
  logic standstill = 1'b0;
  logic [9:0] raw_load = 10'h000;
  int errors = 0;
  int total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  wb_host host_u (.ref_clk(ref_clk), .ack(wb_ack_o), .rdat(wb_dat_o), .cyc(wb_cyc_i), .stb(wb_stb_i),
    .we(wb_we_i), .adr(wb_adr_i), .sel(wb_sel_i), .wdat(wb_dat_i));
  driver_diag dut_u (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .die_temp(die_temp), .short_a_pin(short_pin[0]),
    .short_b_pin(short_pin[1]), .current_low_a_pin(low_pin[0]), .current_low_b_pin(low_pin[1]),
    .fullstep(fullstep), .standstill(standstill), .raw_load(raw_load), .bridge_a_on(bridge_a_on),
    .bridge_b_on(bridge_b_on));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.access(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    host_u.access(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic pins(input logic [2:0] e);
    repeat (4) @(negedge ref_clk);
    chk({29'h0, irq, bridge_a_on, bridge_b_on}, {29'h0, e});
  endtask
  task automatic step(input logic [9:0] l);
    @(posedge ref_clk);
    raw_load <= l;
    fullstep <= 1'b1;
    @(posedge ref_clk);
    fullstep <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic meas(input logic [6:0] t, input logic [9:0] l, input logic [31:0] e);
    wr(diag_pkg::ADR_THRESHOLD, {25'h0, t});
    step(l);
    rchk(diag_pkg::ADR_STATUS, 32'h3FF, e);
  endtask
  task automatic heat(input logic [7:0] t, input logic [31:0] e, input logic [2:0] p);
    @(posedge ref_clk);
    die_temp <= t;
    pins(p);
    rchk(diag_pkg::ADR_STATUS, 32'h3000000, e);
  endtask
  task automatic zap(input int i);
    @(posedge ref_clk);
    short_pin <= 2'(1 << i);
    repeat (8) @(posedge ref_clk);
    short_pin <= 2'h0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(diag_pkg::ADR_CONTROL, 32'hFFFFFFFF, 32'h0);
    rchk(diag_pkg::ADR_THRESHOLD, 32'h7F, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    pins(3'b000);
    wr(diag_pkg::ADR_IRQ_MASK, 32'h40);
    wr(diag_pkg::ADR_CONTROL, 32'h1);
    rchk(diag_pkg::ADR_IRQ_STATUS, 32'h7F, 32'h0);
    meas(7'h00, 10'h064, 32'h064);
    pins(3'b111);
    rchk(diag_pkg::ADR_IRQ_STATUS, 32'h40, 32'h40);
    pins(3'b011);
    meas(7'h3F, 10'h064, 32'h25C);
    meas(7'h40, 10'h064, 32'h0);
    wr(diag_pkg::ADR_THRESHOLD, 32'h0);
    wr(diag_pkg::ADR_CONTROL, 32'h3);
    for (int k = 0; k < 8; k++)
      step(10'(80 * (k % 4 + 1)));
    rchk(diag_pkg::ADR_STATUS, 32'h3FF, 32'h0C8);
    wr(diag_pkg::ADR_CONTROL, 32'h1);
    rchk(diag_pkg::ADR_IRQ_STATUS, 32'h40, 32'h40);
    heat(8'h78, 32'h2000000, 3'b011);
    heat(8'h95, 32'h2000000, 3'b011);
    heat(8'h96, 32'h3000000, 3'b000);
    heat(8'h7D, 32'h3000000, 3'b000);
    heat(8'h77, 32'h0, 3'b011);
    rchk(diag_pkg::ADR_IRQ_STATUS, 32'h7F, 32'h03);
    for (int i = 0; i < 2; i++)
    begin
      repeat (3) zap(i);
      rchk(diag_pkg::ADR_STATUS, 32'hC000000, 32'h0);
      zap(i);
      rchk(diag_pkg::ADR_STATUS, 32'hC000000, 32'h4000000 << i);
      rchk(diag_pkg::ADR_IRQ_STATUS, 32'h7F, 32'h4 << i);
      pins(i ? 3'b010 : 3'b001);
      wr(diag_pkg::ADR_CONTROL, 32'h0);
      wr(diag_pkg::ADR_CONTROL, 32'h1);
      rchk(diag_pkg::ADR_STATUS, 32'hC000000, 32'h0);
      pins(3'b011);
    end
    @(posedge ref_clk);
    standstill <= 1'b1;
    low_pin <= 2'h3;
    repeat (2) step(10'h064);
    rchk(diag_pkg::ADR_STATUS, 32'hB0000000, 32'h80000000);
    @(posedge ref_clk);
    standstill <= 1'b0;
    repeat (4) step(10'h064);
    rchk(diag_pkg::ADR_STATUS, 32'hB0000000, 32'h30000000);
    pins(3'b111);
    rchk(diag_pkg::ADR_IRQ_STATUS, 32'h7F, 32'h70);
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
